// [core/pin_mux_defines.vh]
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH

// register byte offsets
`define PBM_ADDR_W 8
`define PBM_OFFS_SEL_LOW 8'h00
`define PBM_OFFS_SEL_HIGH 8'h04

// reset values and implemented bits
`define PBM_RST_SEL_LOW 32'h00000000
`define PBM_RST_SEL_HIGH 32'h00000000
`define PBM_MASK_SEL_LOW 32'h0000000f
`define PBM_MASK_SEL_HIGH 32'hffffffff

// field positions in the low register
`define PBM_PIN32_LSB 0
`define PBM_PIN33_LSB 2

// select codes
`define PBM_SEL_GPIO 2'b00
`define PBM_SEL_ALT1 2'b01
`define PBM_SEL_ALT2 2'b10
`define PBM_SEL_ALT3 2'b11

// pin index: 0 pin32, 1 pin33, 2..17 pin48..pin63
`define PBM_NPIN 18
// per-alternative capability, one bit per pin index
`define PBM_ALT1_DRV 18'h2ffcf
`define PBM_ALT1_RCV 18'h1ffff
`define PBM_ALT2_DRV 18'h3fffe
`define PBM_ALT2_RCV 18'h3fffd
`define PBM_ALT3_DRV 18'h3fc3f
`define PBM_ALT3_RCV 18'h00f3c
// code 11 reserved on pin52 and pin53
`define PBM_ALT3_RSV 18'h000c0
// i2c lines on alternative 1 are open drain
`define PBM_ALT1_OD 18'h00003

// axi responses
`define PBM_RESP_OKAY 2'b00
`define PBM_RESP_SLVERR 2'b10

`endif

// [core/port_b_upper_pin_function_mux.v]
// Function
// - pin33 select bits 3:2, four sources
// - pin32 select bits 1:0, four sources
// - pin63 select bits 31:30
// - pin62 select bits 29:28
// - pin61 select bits 27:26
// - pin60 select bits 25:24
// - pin59 select bits 23:22
// - pin58 select bits 21:20
// - pin57 select bits 19:18
// - pin56 select bits 17:16
// - pin55 select bits 15:14
// - pin54 select bits 13:12
// - pin53 select bits 11:10, code 11 reserved
// - pin52 select bits 9:8, code 11 reserved
// - pin51 select bits 7:6
// - pin50 select bits 5:4
// - fields default 00, pins start as GPIO
// - high register fields read/write, reset zero
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pin_mux_defines.vh"

module port_b_upper_pin_function_mux (
  input wire CORE_CLK,
  input wire RST_N,
  input wire [`PBM_ADDR_W-1:0] AWADDR,
  input wire [2:0] AWPROT,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  input wire [`PBM_ADDR_W-1:0] ARADDR,
  input wire [2:0] ARPROT,
  input wire ARVALID,
  output wire ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  input wire [`PBM_NPIN-1:0] GPIO_OUT,
  input wire [`PBM_NPIN-1:0] GPIO_OE,
  output wire [`PBM_NPIN-1:0] GPIO_IN,
  input wire [`PBM_NPIN-1:0] ALT1_OUT,
  input wire [`PBM_NPIN-1:0] ALT1_OE,
  output wire [`PBM_NPIN-1:0] ALT1_IN,
  input wire [`PBM_NPIN-1:0] ALT2_OUT,
  input wire [`PBM_NPIN-1:0] ALT2_OE,
  output wire [`PBM_NPIN-1:0] ALT2_IN,
  input wire [`PBM_NPIN-1:0] ALT3_OUT,
  input wire [`PBM_NPIN-1:0] ALT3_OE,
  output wire [`PBM_NPIN-1:0] ALT3_IN,
  input wire [`PBM_NPIN-1:0] PAD_IN,
  output wire [`PBM_NPIN-1:0] PAD_OUT,
  output wire [`PBM_NPIN-1:0] PAD_OE,
  output wire [31:0] SEL_LOW,
  output wire [31:0] SEL_HIGH
);

  localparam NPIN = `PBM_NPIN;

  function [31:0] merge_bytes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      merge_bytes = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge_bytes[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  reg [31:0] sel_low_q;
  reg [31:0] sel_high_q;

  // write channel
  // address and data may arrive in either order; each is parked until
  // its partner comes, and both stay refused while the response waits
  // so a second write can never overtake the first
  reg aw_got_q;
  reg w_got_q;
  reg [`PBM_ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  assign AWREADY = ~aw_got_q & ~bvalid_q;
  assign WREADY = ~w_got_q & ~bvalid_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  wire aw_fire = AWVALID & AWREADY;
  wire w_fire = WVALID & WREADY;
  wire aw_have = aw_got_q | aw_fire;
  wire w_have = w_got_q | w_fire;
  wire do_write = aw_have & w_have & ~bvalid_q;
  wire [`PBM_ADDR_W-1:0] wr_addr = aw_got_q ? awaddr_q : AWADDR;
  wire [31:0] wr_data = w_got_q ? wdata_q : WDATA;
  wire [3:0] wr_strb = w_got_q ? wstrb_q : WSTRB;
  wire [`PBM_ADDR_W-1:0] wr_word = {wr_addr[`PBM_ADDR_W-1:2], 2'b00};
  wire wr_low = (wr_word == `PBM_OFFS_SEL_LOW);
  wire wr_high = (wr_word == `PBM_OFFS_SEL_HIGH);

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= {`PBM_ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PBM_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awaddr_q <= AWADDR;
      end
      if (w_fire) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_low | wr_high) ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_got_q <= 1'b1;
        end
        if (w_fire) begin
          w_got_q <= 1'b1;
        end
        if (bvalid_q & BREADY) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // select registers; reserved codes are stored as written
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sel_low_q <= `PBM_RST_SEL_LOW;
      sel_high_q <= `PBM_RST_SEL_HIGH;
    end else if (do_write) begin
      if (wr_low) begin
        sel_low_q <= merge_bytes(sel_low_q, wr_data, wr_strb) & `PBM_MASK_SEL_LOW;
      end else if (wr_high) begin
        sel_high_q <= merge_bytes(sel_high_q, wr_data, wr_strb);
      end
    end
  end

  // read channel
  // one read at a time: the address is only looked at while no data waits
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire [`PBM_ADDR_W-1:0] rd_word = {ARADDR[`PBM_ADDR_W-1:2], 2'b00};
  reg [31:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b0;
    if (rd_word == `PBM_OFFS_SEL_LOW) begin
      rd_mux = sel_low_q;
      rd_hit = 1'b1;
    end else if (rd_word == `PBM_OFFS_SEL_HIGH) begin
      rd_mux = sel_high_q;
      rd_hit = 1'b1;
    end
  end

  assign ARREADY = ~rvalid_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PBM_RESP_OKAY;
    end else if (ARVALID & ~rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
    end else if (rvalid_q & RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign SEL_LOW = sel_low_q;
  assign SEL_HIGH = sel_high_q;

  // pad input synchroniser; the first stage feeds only the second
  reg [NPIN-1:0] pad_meta_q;
  reg [NPIN-1:0] pad_sync_q;
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pad_meta_q <= {NPIN{1'b0}};
      pad_sync_q <= {NPIN{1'b0}};
    end else begin
      pad_meta_q <= PAD_IN;
      pad_sync_q <= pad_meta_q;
    end
  end

  // pin index and its alternatives 01 / 10 / 11; unmarked ones drive and receive
  // 0 pin32: i2c_a_data_line od / modulator_sync_in in / converter_start_a_out out
  // 1 pin33: i2c_a_clock_line od / modulator_sync_out out / converter_start_b_out out
  // 2 pin48: capture / bus data 31 / spi d slave in
  // 3 pin49: capture / bus data 30 / spi d slave out
  // 4 pin50: encoder1_input_a in / bus data 29 / spi_d_clock
  // 5 pin51: encoder1_input_b in / bus data 28 / spi_d_slave_enable
  // 6 pin52: encoder1_strobe / bus data 27 / reserved
  // 7 pin53: encoder1_index / bus data 26 / reserved
  // 8 pin54: spi_a_slave_in / bus data 25 / encoder3_input_a in
  // 9 pin55: spi_a_slave_out / bus data 24 / encoder3_input_b in
  // 10 pin56: spi_a_clock / bus data 23 / encoder3_strobe
  // 11 pin57: spi_a_slave_enable / bus data 22 / encoder3_index
  // 12 pin58: mcsp_a_rx_clock / bus data 21 / modulator7_out_a out
  // 13 pin59: mcsp_a_rx_frame_sync / bus data 20 / modulator7_out_b out
  // 14 pin60: mcsp_b_rx_clock / bus data 19 / modulator8_out_a out
  // 15 pin61: mcsp_b_rx_frame_sync / bus data 18 / modulator8_out_b out
  // 16 pin62: serial_c_receive in / bus data 17 / modulator9_out_a out
  // 17 pin63: serial_c_transmit out / bus data 16 / modulator9_out_b out
  // one two-bit field per pin: pin32, pin33, then pin48..pin63
  wire [2*NPIN-1:0] sel_all = {sel_high_q,
                               sel_low_q[`PBM_PIN33_LSB +: 2],
                               sel_low_q[`PBM_PIN32_LSB +: 2]};

  wire [NPIN-1:0] drv1 = `PBM_ALT1_DRV;
  wire [NPIN-1:0] rcv1 = `PBM_ALT1_RCV;
  wire [NPIN-1:0] drv2 = `PBM_ALT2_DRV;
  wire [NPIN-1:0] rcv2 = `PBM_ALT2_RCV;
  wire [NPIN-1:0] drv3 = `PBM_ALT3_DRV;
  wire [NPIN-1:0] rcv3 = `PBM_ALT3_RCV;
  wire [NPIN-1:0] rsv3 = `PBM_ALT3_RSV;
  wire [NPIN-1:0] od1 = `PBM_ALT1_OD;

  wire [NPIN-1:0] out_d;
  wire [NPIN-1:0] oe_d;
  wire [NPIN-1:0] gin_d;
  wire [NPIN-1:0] in1_d;
  wire [NPIN-1:0] in2_d;
  wire [NPIN-1:0] in3_d;

  genvar i;
  generate
    for (i = 0; i < NPIN; i = i + 1) begin : g_pin
      wire [1:0] raw = sel_all[2*i +: 2];
      // reserved code falls back to the gpio path
      wire rsv = (raw == `PBM_SEL_ALT3) & rsv3[i];
      wire [1:0] sel = rsv ? `PBM_SEL_GPIO : raw;
      reg o;
      reg e;
      always @* begin
        o = GPIO_OUT[i];
        e = GPIO_OE[i];
        case (sel)
          `PBM_SEL_ALT1: begin
            // open drain: only ever pulls low
            if (od1[i]) begin
              o = 1'b0;
              e = ALT1_OE[i] & ~ALT1_OUT[i];
            end else begin
              o = ALT1_OUT[i];
              e = ALT1_OE[i] & drv1[i];
            end
          end
          `PBM_SEL_ALT2: begin
            o = ALT2_OUT[i];
            e = ALT2_OE[i] & drv2[i];
          end
          `PBM_SEL_ALT3: begin
            o = ALT3_OUT[i];
            e = ALT3_OE[i] & drv3[i];
          end
          default: begin
            o = GPIO_OUT[i];
            e = GPIO_OE[i];
          end
        endcase
      end
      assign out_d[i] = o;
      assign oe_d[i] = e;
      // the gpio block keeps seeing the pad, like a real input buffer
      assign gin_d[i] = pad_sync_q[i];
      // unselected peripherals see a quiet low
      assign in1_d[i] = (sel == `PBM_SEL_ALT1) & rcv1[i] & pad_sync_q[i];
      assign in2_d[i] = (sel == `PBM_SEL_ALT2) & rcv2[i] & pad_sync_q[i];
      assign in3_d[i] = (sel == `PBM_SEL_ALT3) & rcv3[i] & pad_sync_q[i];
    end
  endgenerate

  // registered pads cost one cycle of latency but keep a select change
  // from glitching the pin while the mux settles
  reg [NPIN-1:0] pad_out_q;
  reg [NPIN-1:0] pad_oe_q;
  reg [NPIN-1:0] gpio_in_q;
  reg [NPIN-1:0] alt1_in_q;
  reg [NPIN-1:0] alt2_in_q;
  reg [NPIN-1:0] alt3_in_q;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pad_out_q <= {NPIN{1'b0}};
      pad_oe_q <= {NPIN{1'b0}};
      gpio_in_q <= {NPIN{1'b0}};
      alt1_in_q <= {NPIN{1'b0}};
      alt2_in_q <= {NPIN{1'b0}};
      alt3_in_q <= {NPIN{1'b0}};
    end else begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
      gpio_in_q <= gin_d;
      alt1_in_q <= in1_d;
      alt2_in_q <= in2_d;
      alt3_in_q <= in3_d;
    end
  end

  assign PAD_OUT = pad_out_q;
  assign PAD_OE = pad_oe_q;
  assign GPIO_IN = gpio_in_q;
  assign ALT1_IN = alt1_in_q;
  assign ALT2_IN = alt2_in_q;
  assign ALT3_IN = alt3_in_q;

endmodule // port_b_upper_pin_function_mux

// [testbench/pin_mux_monitor.sv]
`timescale 1ns/1ps
`include "pin_mux_defines.vh"
module pin_mux_monitor (
  input wire CORE_CLK,
  input wire RST_N,
  input wire AWVALID,
  input wire AWREADY,
  input wire WVALID,
  input wire WREADY,
  input wire BVALID,
  input wire BREADY,
  input wire [1:0] BRESP,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA,
  input wire [31:0] SEL_LOW,
  input wire [31:0] SEL_HIGH,
  input wire [`PBM_NPIN-1:0] GPIO_OE,
  input wire [`PBM_NPIN-1:0] ALT1_OE,
  input wire [`PBM_NPIN-1:0] ALT1_OUT,
  input wire [`PBM_NPIN-1:0] PAD_OE,
  input wire [`PBM_NPIN-1:0] PAD_OUT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
    else $error("write response late");
  a_bresp_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read response late");
  a_rdata_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("read taken while busy");
  a_low_unused: assert property (SEL_LOW[31:4] == 28'h0)
    else $error("unused low bits stored");
  a_reset_clear: assert property (disable iff (1'b0) !RST_N |=> SEL_HIGH == 32'h0 && SEL_LOW == 32'h0)
    else $error("select not cleared");
  a_gpio_route: assert property (SEL_HIGH[31:30] == 2'b00 |=> PAD_OE[17] == $past(GPIO_OE[17]))
    else $error("pin63 not on gpio");
  a_open_drain: assert property (SEL_LOW[3:2] == 2'b01 |=> !PAD_OUT[1] && PAD_OE[1] == $past(ALT1_OE[1] & ~ALT1_OUT[1]))
    else $error("pin33 not open drain");
  a_reserved_gpio: assert property (SEL_HIGH[11:10] == 2'b11 |=> PAD_OE[7] == $past(GPIO_OE[7]))
    else $error("reserved code routes a peripheral");
endmodule // pin_mux_monitor

// [testbench/pad_periph_model.sv]
`timescale 1ns/1ps
module pad_periph_model (
  input wire [17:0] pad_out,
  input wire [17:0] pad_oe,
  output wire [17:0] go,
  output wire [17:0] ge,
  output wire [17:0] o1,
  output wire [17:0] e1,
  output wire [17:0] o2,
  output wire [17:0] e2,
  output wire [17:0] o3,
  output wire [17:0] e3,
  output wire [17:0] ext,
  output wire [17:0] pad_in
);
  assign go = 18'h0ffff;
  assign ge = 18'h2aaaa;
  assign o1 = 18'h15555;
  assign e1 = 18'h3ffff;
  assign o2 = 18'h0cccc;
  assign e2 = 18'h3ffff;
  assign o3 = 18'h33333;
  assign e3 = 18'h1ffff;
  // outside driver on pins the chip leaves undriven
  assign ext = 18'h1e1e1;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule // pad_periph_model

// [testbench/port_b_upper_pin_function_mux_test.sv]
`timescale 1ns/1ps
`include "pin_mux_defines.vh"
module port_b_upper_pin_function_mux_test;
  reg CORE_CLK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  reg [7:0] AWADDR = 0, ARADDR = 0;
  reg [31:0] WDATA = 0, d;
  reg [3:0] WSTRB = 4'hf;
  reg [1:0] r, c;
  reg [17:0] g, od, n, eoe, eout, epad, ein;
  integer failures = 0, tests_run = 0, cyc = 0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA, SEL_LOW, SEL_HIGH;
  wire [17:0] go, ge, gi, o1, e1, i1, o2, e2, i2, o3, e3, i3, pi, po, pe, ext;
  always #5 CORE_CLK = ~CORE_CLK;
  port_b_upper_pin_function_mux u_dut (.CORE_CLK, .RST_N, .AWADDR, .AWPROT(3'h0), .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARPROT(3'h0), .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .GPIO_OUT(go),
    .GPIO_OE(ge), .GPIO_IN(gi), .ALT1_OUT(o1), .ALT1_OE(e1), .ALT1_IN(i1), .ALT2_OUT(o2),
    .ALT2_OE(e2), .ALT2_IN(i2), .ALT3_OUT(o3), .ALT3_OE(e3), .ALT3_IN(i3), .PAD_IN(pi),
    .PAD_OUT(po), .PAD_OE(pe), .SEL_LOW, .SEL_HIGH);
  pad_periph_model u_far (.pad_out(po), .pad_oe(pe), .go, .ge, .o1, .e1, .o2, .e2, .o3, .e3,
    .ext, .pad_in(pi));
  function [17:0] pick(input [1:0] k, input [17:0] a, input [17:0] b, input [17:0] x);
    pick = k == 2'd1 ? a : (k == 2'd2 ? b : x);
  endfunction
  task chk(input string nm, input [63:0] e, input [63:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [3:0] s, output [1:0] rs);
    @(posedge CORE_CLK);
    AWADDR <= a; WDATA <= v; WSTRB <= s; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    do begin
      @(posedge CORE_CLK);
      if (AWREADY) AWVALID <= 0;
      if (WREADY) WVALID <= 0;
    end while (BVALID !== 1'b1);
    BREADY <= 0; rs = BRESP;
  endtask
  task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
    @(posedge CORE_CLK);
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    do begin
      @(posedge CORE_CLK);
      if (ARREADY) ARVALID <= 0;
    end while (RVALID !== 1'b1);
    RREADY <= 0; v = RDATA; rs = RRESP;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1;
    rd(8'h04, d, r); chk("high reset", 0, {r, d});
    rd(8'h00, d, r); chk("low reset", 0, {r, d});
    $display("test reset done");
    wr(8'h04, 32'hffffffff, 4'hf, r); wr(8'h04, 32'h0, 4'h2, r);
    rd(8'h04, d, r); chk("high strobe", 32'hffff00ff, d);
    wr(8'h00, 32'hffffffff, 4'hf, r); rd(8'h00, d, r); chk("low mask", 32'hf, d);
    wr(8'h10, 32'h1, 4'hf, r); chk("bad wr", `PBM_RESP_SLVERR, r);
    rd(8'h10, d, r); chk("bad rd", {`PBM_RESP_SLVERR, 32'h0}, {r, d});
    $display("test access done");
    for (int k = 0; k < 4; k++) begin
      c = k;
      wr(8'h00, {28'h0, c, c}, 4'hf, r); wr(8'h04, {16{c}}, 4'hf, r);
      rd(8'h04, d, r); chk("high back", {16{c}}, d);
      repeat (5) @(posedge CORE_CLK);
      g = c == 2'd0 ? 18'h3ffff : (c == 2'd3 ? `PBM_ALT3_RSV : 18'h0);
      od = c == 2'd1 ? `PBM_ALT1_OD : 18'h0;
      n = ~g & ~od;
      eoe = g & ge | od & e1 & ~o1 | n & pick(c, e1, e2, e3)
        & pick(c, `PBM_ALT1_DRV, `PBM_ALT2_DRV, `PBM_ALT3_DRV);
      eout = g & go | n & pick(c, o1, o2, o3);
      epad = eoe & eout | ~eoe & ext;
      ein = (n | od) & epad & pick(c, `PBM_ALT1_RCV, `PBM_ALT2_RCV, `PBM_ALT3_RCV);
      chk("pad oe", eoe, pe);
      chk("pad out", eout & eoe, po & eoe);
      chk("gpio in", epad, gi);
      chk("alt in", {c == 1 ? ein : 18'h0, c == 2 ? ein : 18'h0, c == 3 ? ein : 18'h0},
        {i1, i2, i3});
      $display("test code %0d done", k);
    end
    final_report;
  end
endmodule // port_b_upper_pin_function_mux_test
bind port_b_upper_pin_function_mux pin_mux_monitor u_mon (.CORE_CLK, .RST_N, .AWVALID,
  .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY,
  .RDATA, .SEL_LOW, .SEL_HIGH, .GPIO_OE, .ALT1_OE, .ALT1_OUT, .PAD_OE, .PAD_OUT);
